// file: inc/atx_pkg.sv
// What the document requires
// [R1] frames are NRZ: one start bit, eight or nine data bits, one stop bit
// [R2] data bits leave the line least significant bit first
// [R3] a dedicated 8-bit baud generator runs from the system clock
// [R4] generator output is x16 bit rate with high speed set, x64 when clear
// [R5] transmit and receive share one format and one baud setting
// [R6] no parity hardware; software may carry parity in the ninth bit
// [R7] all asynchronous activity halts while the device sleeps
// [R8] asynchronous mode is selected by a clear sync select, control bit 4
// [R9] shifter reloads only after the stop bit, then at once if buffer holds data
// [R10] buffer-to-shifter move takes one cycle and sets the flag, flag bit 4
// [R11] flag is set regardless of enable; only a buffer write clears it
// [R12] interrupt request is the flag gated by enable register bit 4
// [R13] read-only shifter empty status at control bit 1, no interrupt
// [R14] the shift register is not reachable by software
// [R15] setting transmitter enable sets the buffer empty flag
// [R16] output starts once buffer holds data and a shift clock occurred
// [R17] loading the buffer before enabling also starts correctly
// [R18] a write with empty shifter passes straight into the shifter
// [R19] clearing transmitter enable aborts the frame and floats the pin
// [R20] software writes nine-bit select and ninth bit before the data byte
// [R21] software configures baud, port, options, enable, ninth bit, then data
// [R22] bit rate is clock over 64(divisor+1) low speed, 16(divisor+1) high
// [R23] writing the divisor clears the baud timer
// [R24] port enable hands the pins to the port; clearing disables it
// [R25] idle line rests high; start bit low, stop bit high
package atx_pkg;
  // register offsets
  localparam logic [7:0] ATX_OFS_FLAG = 8'h0C;
  localparam logic [7:0] ATX_OFS_PORT = 8'h18;
  localparam logic [7:0] ATX_OFS_BUF = 8'h19;
  localparam logic [7:0] ATX_OFS_IEN = 8'h8C;
  localparam logic [7:0] ATX_OFS_CTRL = 8'h98;
  localparam logic [7:0] ATX_OFS_DIV = 8'h99;
  // field positions
  localparam int ATX_B_CSRC = 7;
  localparam int ATX_B_NINE = 6;
  localparam int ATX_B_TXON = 5;
  localparam int ATX_B_SYNC = 4;
  localparam int ATX_B_HS = 2;
  localparam int ATX_B_SHEMPTY = 1;
  localparam int ATX_B_NINTH = 0;
  localparam int ATX_B_PORTON = 7;
  localparam int ATX_B_FLAG = 4;
  localparam int ATX_B_IEN = 4;
  // reset values
  localparam logic [7:0] ATX_RST_CTRL = 8'h02;
  localparam logic [7:0] ATX_RST_DIV = 8'h00;
  localparam logic [7:0] ATX_RST_BUF = 8'h00;
  // oversampling terminal counts
  localparam logic [5:0] ATX_OVS_HI = 6'h0F;
  localparam logic [5:0] ATX_OVS_LO = 6'h3F;
  // last data bit index for 8 and 9 bit frames
  localparam logic [3:0] ATX_LAST8 = 4'h7;
  localparam logic [3:0] ATX_LAST9 = 4'h8;
  // transmitter states
  typedef enum logic [2:0] {
    S_IDLE,
    S_READY,
    S_START,
    S_DATA,
    S_STOP
  } atx_state_t;
endpackage

// file: hw/atx_async_tx.sv
// Chosen here: the address map and the strobed register port.
`timescale 1ns/100ps
module atx_async_tx (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic sleepReq,
  output logic [7:0] regRdData,
  output logic txOut,
  output logic txOe,
  output logic txIrqReq
);

  // software-visible state
  logic clkSrc_reg;
  logic nineSel_reg;
  logic transmitter_enable_reg;
  logic syncSel_reg;
  logic hsSel_reg;
  logic ninthBit_reg;
  logic portEn_reg;
  logic irqEn_reg;
  logic [7:0] divisor_reg;
  logic [7:0] bufData_reg;
  logic bufFull_reg;
  logic flag_reg;
  // baud generator
  logic [7:0] baudCnt_reg;
  logic [5:0] subCnt_reg;
  // transmit shifter, hidden from software
  atx_pkg::atx_state_t state_reg;
  atx_pkg::atx_state_t state_next;
  logic [8:0] shift_reg;
  logic [3:0] bitCnt_reg;
  logic frameNine_reg;
  // registered outputs
  logic txOut_reg;
  logic txOe_reg;
  logic irq_reg;
  logic [7:0] rdData_reg;

  // address decode
  wire wrCtrl = regWr && (regAddr == atx_pkg::ATX_OFS_CTRL);
  wire wrPort = regWr && (regAddr == atx_pkg::ATX_OFS_PORT);
  wire wrBuf = regWr && (regAddr == atx_pkg::ATX_OFS_BUF);
  wire wrIen = regWr && (regAddr == atx_pkg::ATX_OFS_IEN);
  wire wrDiv = regWr && (regAddr == atx_pkg::ATX_OFS_DIV);

  // mode and enable terms
  wire asyncMode = portEn_reg && !syncSel_reg; // [R8] [R24]
  wire txActive = asyncMode && transmitter_enable_reg; // [R19]
  wire runBaud = asyncMode && !sleepReq; // [R5] [R7]
  wire txEnRise = wrCtrl && regWrData[atx_pkg::ATX_B_TXON] && !transmitter_enable_reg;

  // baud timer terms
  wire baudTick = runBaud && (baudCnt_reg == divisor_reg); // [R22]
  wire [5:0] subMax = hsSel_reg ? atx_pkg::ATX_OVS_HI : atx_pkg::ATX_OVS_LO; // [R4]
  wire bitTick = baudTick && (subCnt_reg == subMax);

  // transmitter terms
  wire shEmpty = (state_reg == atx_pkg::S_IDLE); // [R13]
  wire loadNow = txActive && !sleepReq && shEmpty && bufFull_reg; // [R9] [R18]
  wire [3:0] lastBit = frameNine_reg ? atx_pkg::ATX_LAST9 : atx_pkg::ATX_LAST8;
  wire lastData = (bitCnt_reg == lastBit);

  // control register bits
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      clkSrc_reg <= atx_pkg::ATX_RST_CTRL[atx_pkg::ATX_B_CSRC];
      nineSel_reg <= atx_pkg::ATX_RST_CTRL[atx_pkg::ATX_B_NINE];
      transmitter_enable_reg <= atx_pkg::ATX_RST_CTRL[atx_pkg::ATX_B_TXON];
      syncSel_reg <= atx_pkg::ATX_RST_CTRL[atx_pkg::ATX_B_SYNC];
      hsSel_reg <= atx_pkg::ATX_RST_CTRL[atx_pkg::ATX_B_HS];
      ninthBit_reg <= atx_pkg::ATX_RST_CTRL[atx_pkg::ATX_B_NINTH];
    end else if (wrCtrl) begin
      clkSrc_reg <= regWrData[atx_pkg::ATX_B_CSRC];
      nineSel_reg <= regWrData[atx_pkg::ATX_B_NINE];
      transmitter_enable_reg <= regWrData[atx_pkg::ATX_B_TXON];
      syncSel_reg <= regWrData[atx_pkg::ATX_B_SYNC];
      hsSel_reg <= regWrData[atx_pkg::ATX_B_HS];
      ninthBit_reg <= regWrData[atx_pkg::ATX_B_NINTH];
    end
  end

  // port enable and interrupt enable
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      portEn_reg <= 1'b0;
      irqEn_reg <= 1'b0;
    end else begin
      if (wrPort) begin
        portEn_reg <= regWrData[atx_pkg::ATX_B_PORTON]; // [R24]
      end
      if (wrIen) begin
        irqEn_reg <= regWrData[atx_pkg::ATX_B_IEN];
      end
    end
  end

  // divisor register
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      divisor_reg <= atx_pkg::ATX_RST_DIV;
    end else if (wrDiv) begin
      divisor_reg <= regWrData;
    end
  end

  // baud timer and oversampling divider, cleared by a divisor write
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      baudCnt_reg <= 8'h00;
      subCnt_reg <= 6'h00;
    end else if (wrDiv) begin
      baudCnt_reg <= 8'h00; // [R23]
      subCnt_reg <= 6'h00; // [R23]
    end else if (baudTick) begin
      baudCnt_reg <= 8'h00; // [R3]
      subCnt_reg <= bitTick ? 6'h00 : subCnt_reg + 6'h01; // [R4]
    end else if (runBaud) begin
      baudCnt_reg <= baudCnt_reg + 8'h01; // [R3]
    end
  end

  // transmit buffer; it survives a disable so a preloaded byte still goes
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      bufData_reg <= atx_pkg::ATX_RST_BUF;
      bufFull_reg <= 1'b0;
    end else if (wrBuf) begin
      bufData_reg <= regWrData;
      bufFull_reg <= 1'b1; // [R17]
    end else if (loadNow) begin
      bufFull_reg <= 1'b0; // [R10]
    end
  end

  // buffer empty flag: only a buffer write clears it
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      flag_reg <= 1'b0;
    end else if (wrBuf) begin
      flag_reg <= 1'b0; // [R11]
    end else if (loadNow || txEnRise) begin
      flag_reg <= 1'b1; // [R10] [R15]
    end
  end

  // next state of the shifter sequence
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      atx_pkg::S_IDLE: begin
        if (loadNow) begin
          state_next = atx_pkg::S_READY;
        end
      end
      atx_pkg::S_READY: begin
        if (bitTick) begin
          state_next = atx_pkg::S_START; // [R16]
        end
      end
      atx_pkg::S_START: begin
        if (bitTick) begin
          state_next = atx_pkg::S_DATA;
        end
      end
      atx_pkg::S_DATA: begin
        if (bitTick && lastData) begin
          state_next = atx_pkg::S_STOP; // [R1]
        end
      end
      atx_pkg::S_STOP: begin
        if (bitTick) begin
          state_next = atx_pkg::S_IDLE; // [R9]
        end
      end
      default: begin
        state_next = atx_pkg::S_IDLE;
      end
    endcase
    if (!txActive) begin
      state_next = atx_pkg::S_IDLE; // [R19]
    end
  end

  // state register
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= atx_pkg::S_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // shifter load and shift; ninth bit is taken as software left it
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      shift_reg <= 9'h000;
      bitCnt_reg <= 4'h0;
      frameNine_reg <= 1'b0;
    end else if (loadNow) begin
      shift_reg <= {ninthBit_reg, bufData_reg}; // [R6] [R18]
      frameNine_reg <= nineSel_reg; // [R1]
      bitCnt_reg <= 4'h0;
    end else if (state_reg == atx_pkg::S_DATA && bitTick) begin
      shift_reg <= {1'b0, shift_reg[8:1]}; // [R2]
      bitCnt_reg <= bitCnt_reg + 4'h1;
    end
  end

  // line level for the current state
  logic lineLvl;
  always_comb begin
    case (state_reg)
      atx_pkg::S_START: lineLvl = 1'b0; // [R25]
      atx_pkg::S_DATA: lineLvl = shift_reg[0]; // [R2]
      default: lineLvl = 1'b1; // [R25]
    endcase
  end

  // pin drive, floats whenever the transmitter is not active
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      txOut_reg <= 1'b1;
      txOe_reg <= 1'b0;
    end else begin
      txOut_reg <= lineLvl;
      txOe_reg <= txActive; // [R19] [R24]
    end
  end

  // interrupt request, gated by its enable
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= flag_reg && irqEn_reg; // [R12]
    end
  end

  // read multiplexer; the shifter itself has no address
  wire [7:0] ctrlRd = {clkSrc_reg, nineSel_reg, transmitter_enable_reg, syncSel_reg,
                       1'b0, hsSel_reg, shEmpty, ninthBit_reg}; // [R13]
  wire [7:0] portRd = {portEn_reg, 7'h00};
  wire [7:0] flagRd = {3'h0, flag_reg, 4'h0};
  wire [7:0] ienRd = {3'h0, irqEn_reg, 4'h0};
  wire [7:0] rdMux =
    (regAddr == atx_pkg::ATX_OFS_CTRL) ? ctrlRd :
    (regAddr == atx_pkg::ATX_OFS_PORT) ? portRd :
    (regAddr == atx_pkg::ATX_OFS_FLAG) ? flagRd :
    (regAddr == atx_pkg::ATX_OFS_IEN) ? ienRd :
    (regAddr == atx_pkg::ATX_OFS_BUF) ? bufData_reg :
    (regAddr == atx_pkg::ATX_OFS_DIV) ? divisor_reg :
    8'h00; // [R14]

  // read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rdData_reg <= 8'h00;
    end else begin
      rdData_reg <= regRd ? rdMux : 8'h00;
    end
  end

  // outputs
  assign regRdData = rdData_reg;
  assign txOut = txOut_reg;
  assign txOe = txOe_reg;
  assign txIrqReq = irq_reg;

  // check helpers: cycles since the last bit tick and the expected bit period
  logic [14:0] ovsCyc_reg;
  logic ovsValid_reg;
  wire [14:0] ovsRatio = hsSel_reg ? 15'(atx_pkg::ATX_OVS_HI) + 15'h0001 :
                         15'(atx_pkg::ATX_OVS_LO) + 15'h0001;
  wire [14:0] bitPeriod = (15'(divisor_reg) + 15'h0001) * ovsRatio;

  // a control write may leave a partial period, so the next one is not checked
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ovsCyc_reg <= 15'h0000;
      ovsValid_reg <= 1'b0;
    end else if (wrDiv) begin
      ovsCyc_reg <= 15'h0000;
      ovsValid_reg <= 1'b1;
    end else if (wrCtrl) begin
      ovsCyc_reg <= 15'h0000;
      ovsValid_reg <= 1'b0;
    end else if (bitTick) begin
      ovsCyc_reg <= 15'h0000;
      ovsValid_reg <= 1'b1;
    end else if (runBaud) begin
      ovsCyc_reg <= ovsCyc_reg + 15'h0001;
    end
  end

  // bit ticks seen since the start bit began, for the frame length check
  logic [3:0] frameTicks_reg;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      frameTicks_reg <= 4'h0;
    end else if (loadNow) begin
      frameTicks_reg <= 4'h0;
    end else if (bitTick && !shEmpty && state_reg != atx_pkg::S_READY) begin
      frameTicks_reg <= frameTicks_reg + 4'h1;
    end
  end

  // checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  sequence s_abort;
    state_reg == atx_pkg::S_IDLE && !txOe;
  endsequence

  sequence s_float;
    !txOe && shEmpty;
  endsequence

  property p_start_low;
    txActive && state_reg == atx_pkg::S_START |=> txOe && !txOut;
  endproperty
  a_start_low: assert property (p_start_low) else $error("start bit not low"); // [R25]

  property p_stop_high;
    txActive && state_reg == atx_pkg::S_STOP |=> txOe && txOut;
  endproperty
  a_stop_high: assert property (p_stop_high) else $error("stop bit not high"); // [R25]

  property p_lsb_first;
    txActive && state_reg == atx_pkg::S_DATA |=> txOut == $past(shift_reg[0]);
  endproperty
  a_lsb_first: assert property (p_lsb_first) else $error("data bit order wrong"); // [R2]

  property p_load;
    loadNow && !wrBuf |=> flag_reg && !bufFull_reg && state_reg == atx_pkg::S_READY;
  endproperty
  a_load: assert property (p_load) else $error("buffer load not in one cycle"); // [R10]

  property p_flag_clear;
    wrBuf |=> !flag_reg ##1 (flag_reg || bufFull_reg);
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag clear wrong"); // [R11]

  property p_enable_flag;
    txEnRise && !wrBuf |=> flag_reg;
  endproperty
  a_enable_flag: assert property (p_enable_flag) else $error("enable did not set flag"); // [R15]

  property p_pass_through;
    wrBuf && shEmpty && txActive && !sleepReq |=> loadNow ##1 !bufFull_reg;
  endproperty
  a_pass_through: assert property (p_pass_through) else $error("no pass-through"); // [R18]

  property p_abort;
    !transmitter_enable_reg ##1 !transmitter_enable_reg |-> s_abort ##0 s_float;
  endproperty
  a_abort: assert property (p_abort) else $error("disable did not abort"); // [R19]

  property p_div_clear;
    wrDiv |=> baudCnt_reg == 8'h00 && subCnt_reg == 6'h00;
  endproperty
  a_div_clear: assert property (p_div_clear) else $error("divisor write no clear"); // [R23]

  property p_sleep;
    sleepReq && !regWr |=> $stable(baudCnt_reg) && $stable(state_reg);
  endproperty
  a_sleep: assert property (p_sleep) else $error("activity during sleep"); // [R7]

  property p_ovs;
    bitTick && ovsValid_reg |-> ovsCyc_reg == bitPeriod - 15'h0001;
  endproperty
  a_ovs: assert property (p_ovs) else $error("bit period wrong"); // [R4] [R22]

  property p_frame_len;
    txActive && state_reg == atx_pkg::S_STOP && bitTick |->
      frameTicks_reg == (frameNine_reg ? atx_pkg::ATX_LAST9 : atx_pkg::ATX_LAST8) + 4'h2;
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame length wrong"); // [R1]

  property p_irq;
    ##1 txIrqReq == $past(flag_reg && irqEn_reg);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt gating wrong"); // [R12]

endmodule

// file: tb/atx_rx_model.sv
`timescale 1ns/100ps
module atx_rx_model (
  input wire logic sys_clk,
  input wire logic serLine,
  input wire logic [7:0] bitLen,
  input wire logic nineBits,
  output logic [8:0] rxData,
  output logic [7:0] rxCount,
  output logic rxFrameErr
);
  logic [8:0] shiftBuf;
  int nBits;
  initial begin
    rxData = 9'h000;
    rxCount = 8'h00;
    rxFrameErr = 1'b0;
  end
  // find a low start bit, then sample each bit in its middle
  always begin
    @(posedge sys_clk iff (serLine === 1'b0));
    repeat (bitLen / 2) @(posedge sys_clk);
    if (serLine === 1'b0) begin
      nBits = nineBits ? 9 : 8;
      shiftBuf = 9'h000;
      for (int i = 0; i < nBits; i++) begin
        repeat (bitLen) @(posedge sys_clk);
        shiftBuf[i] = serLine;
      end
      repeat (bitLen) @(posedge sys_clk);
      rxFrameErr = (serLine !== 1'b1);
      rxData = shiftBuf;
      rxCount = rxCount + 8'h01;
    end
  end
endmodule

// file: tb/atx_async_tx_bench.sv
`timescale 1ns/100ps
module atx_async_tx_bench;
  localparam logic [7:0] aCtrl = atx_pkg::ATX_OFS_CTRL;
  localparam logic [7:0] aFlag = atx_pkg::ATX_OFS_FLAG;
  localparam logic [7:0] aBuf = atx_pkg::ATX_OFS_BUF;
  localparam logic [7:0] aDiv = atx_pkg::ATX_OFS_DIV;
  localparam logic [7:0] aIen = atx_pkg::ATX_OFS_IEN;
  localparam logic [7:0] aPort = atx_pkg::ATX_OFS_PORT;
  logic sys_clk, resetn, regWr, regRd, sleepReq, txOut, txOe, txIrqReq, nineBits, rxFrameErr;
  logic [7:0] regAddr, regWrData, regRdData, bitLen, rxCount, rxSeen;
  logic [8:0] rxData;
  logic [7:0] rstAddr [7] = '{aCtrl, aPort, aDiv, aBuf, aFlag, aIen, 8'h55};
  logic [7:0] rstVal [7] = '{8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  int numErrors = 0;
  int checkCount = 0;
  // released line is pulled high
  wire serLine = txOe ? txOut : 1'b1;

  atx_async_tx atx_async_tx_i (
    .sys_clk(sys_clk), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .sleepReq(sleepReq), .regRdData(regRdData),
    .txOut(txOut), .txOe(txOe), .txIrqReq(txIrqReq)
  );
  atx_rx_model atx_rx_model_i (
    .sys_clk(sys_clk), .serLine(serLine), .bitLen(bitLen), .nineBits(nineBits),
    .rxData(rxData), .rxCount(rxCount), .rxFrameErr(rxFrameErr)
  );

  // clock generation
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic cmp(input string n, input logic [8:0] e, input logic [8:0] g);
    checkCount++;
    if (g !== e) begin
      $display("unexpected %s: expected %h, seen %h", n, e, g);
      numErrors++;
    end
  endtask

  task automatic pin(input string n, input logic e, input logic g);
    cmp(n, {8'h00, e}, {8'h00, g});
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1;
    cmp($sformatf("register %h", a), {1'b0, e}, {1'b0, regRdData});
  endtask

  task automatic finishTest();
    $display("checks %0d, mismatches %0d", checkCount, numErrors);
    if (numErrors == 0 && checkCount > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // wait for the next whole frame at the far side, bounded
  task automatic waitRx(input logic [8:0] e);
    int n = 0;
    while (rxCount === rxSeen && n < 4000) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 4000) begin
      $display("unexpected frame timeout: expected %h, seen none", e);
      numErrors++;
      finishTest();
    end else begin
      rxSeen = rxCount;
      cmp("received frame", e, rxData);
      pin("stop bit error", 1'b0, rxFrameErr);
    end
  endtask

  initial begin
    resetn = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    sleepReq = 1'b0;
    nineBits = 1'b0;
    bitLen = 8'h10;
    rxSeen = 8'h00;
    repeat (16) @(posedge sys_clk);
    resetn <= 1'b1;
    // reset values and an unmapped place
    wr(8'h55, 8'hFF);
    for (int i = 0; i < 7; i++) rd(rstAddr[i], rstVal[i]);
    $display("test reset finished");
    // high speed, divisor 0: 16 cycles a bit, back-to-back bytes
    wr(aDiv, 8'h00);
    wr(aPort, 8'h80);
    wr(aIen, 8'h10);
    wr(aCtrl, 8'h24);
    idle(3);
    pin("txOe", 1'b1, txOe);
    pin("txOut idle", 1'b1, txOut);
    pin("txIrqReq", 1'b1, txIrqReq);
    rd(aFlag, 8'h10);
    wr(aBuf, 8'hA5);
    wr(aBuf, 8'h3C);
    rd(aFlag, 8'h00);
    rd(aCtrl, 8'h24);
    waitRx(9'h0A5);
    waitRx(9'h03C);
    idle(20);
    rd(aCtrl, 8'h26);
    rd(aFlag, 8'h10);
    wr(aFlag, 8'h00);
    rd(aFlag, 8'h10);
    wr(aIen, 8'h00);
    idle(3);
    pin("txIrqReq masked", 1'b0, txIrqReq);
    $display("test back to back finished");
    // nine-bit frames, ninth bit written first
    nineBits = 1'b1;
    wr(aCtrl, 8'h65);
    wr(aBuf, 8'h5A);
    waitRx(9'h15A);
    idle(20);
    wr(aCtrl, 8'h64);
    wr(aBuf, 8'hC3);
    waitRx(9'h0C3);
    idle(20);
    $display("test nine bit finished");
    // low speed, divisor 1, buffer loaded before enable
    nineBits = 1'b0;
    wr(aCtrl, 8'h00);
    wr(aDiv, 8'h01);
    bitLen = 8'h80;
    wr(aBuf, 8'h81);
    wr(aCtrl, 8'h20);
    waitRx(9'h081);
    idle(150);
    $display("test low speed finished");
    // sleep freezes the transmitter
    wr(aDiv, 8'h00);
    bitLen = 8'h10;
    wr(aCtrl, 8'h24);
    @(posedge sys_clk);
    sleepReq <= 1'b1;
    wr(aBuf, 8'h77);
    idle(300);
    pin("txOut in sleep", 1'b1, txOut);
    cmp("frames in sleep", {1'b0, rxSeen}, {1'b0, rxCount});
    @(posedge sys_clk);
    sleepReq <= 1'b0;
    waitRx(9'h077);
    idle(20);
    $display("test sleep finished");
    // synchronous select releases the pin
    wr(aCtrl, 8'h34);
    idle(2);
    pin("txOe sync", 1'b0, txOe);
    wr(aCtrl, 8'h24);
    // abort in mid-frame
    wr(aBuf, 8'hFF);
    idle(40);
    wr(aCtrl, 8'h04);
    idle(1);
    pin("txOe abort", 1'b0, txOe);
    rd(aCtrl, 8'h06);
    $display("test abort finished");
    finishTest();
  end
endmodule
